// [inc/cdac_pkg.sv]
package cdac_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned POS_SEL_W = 2;
    localparam int unsigned NEG_SEL_W = 3;
    localparam int unsigned CODE_W = 10;
    localparam int unsigned SYNC_W = 4;

    // ------------------------------------------------------------------
    // register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CMP_A_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMP_B_CTRL = 8'h04;
    localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h08;
    localparam logic [7:0] OFS_DAC0_HOLD = 8'h0c;
    localparam logic [7:0] OFS_DAC1_HOLD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_DAC_APPLIED = 8'h18;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CFG_W = 8;
    localparam int unsigned GLB_W = 6;
    localparam int unsigned CFG_ENABLE_N_BIT = 0;
    localparam int unsigned ST_CMP_A_BIT = 0;
    localparam int unsigned ST_CMP_B_BIT = 1;
    localparam int unsigned ST_PEND0_BIT = 2;
    localparam int unsigned ST_PEND1_BIT = 3;
    localparam int unsigned APPLIED_DAC1_LSB = 16;

    // sync vector lanes
    localparam int unsigned LANE_CMP_A = 0;
    localparam int unsigned LANE_CMP_B = 1;
    localparam int unsigned LANE_TRIG0 = 2;
    localparam int unsigned LANE_TRIG1 = 3;

    // ------------------------------------------------------------------
    // select encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] POS_SEL_INPUT1 = 2'h1;
    localparam logic [1:0] POS_SEL_INPUT2 = 2'h2;
    localparam logic [2:0] NEG_SEL_INPUT1 = 3'h1;
    localparam logic [2:0] NEG_SEL_INPUT2 = 3'h2;
    localparam logic [2:0] NEG_SEL_INPUT3 = 3'h3;
    localparam logic [2:0] NEG_SEL_REF_QUARTER = 3'h4;
    localparam logic [2:0] NEG_SEL_REF_HALF = 3'h5;
    localparam logic [2:0] NEG_SEL_REF_3QUARTER = 3'h6;
    localparam logic [2:0] NEG_SEL_REF_FULL = 3'h7;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    // one comparator's control set; packed layout equals the register layout
    typedef struct packed {
        logic [POS_SEL_W-1:0] pos_select;
        logic [NEG_SEL_W-1:0] neg_select;
        logic speed_power;
        logic hysteresis_on;
        logic enable_n;
    } cdac_cmp_cfg_s;

    // shared stop, converter enables and dual mode
    typedef struct packed {
        logic dual_mode;
        logic dac1_buffer_enable_n;
        logic dac0_buffer_enable_n;
        logic dac_enable_n;
        logic dac_stop;
        logic cmp_stop;
    } cdac_glb_s;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam cdac_cmp_cfg_s CMP_CFG_RST = '{
        pos_select: POS_SEL_INPUT1,
        neg_select: NEG_SEL_INPUT1,
        speed_power: 1'b0,
        hysteresis_on: 1'b0,
        enable_n: 1'b1
    };
    localparam cdac_glb_s GLB_RST = '{
        dual_mode: 1'b0,
        dac1_buffer_enable_n: 1'b1,
        dac0_buffer_enable_n: 1'b1,
        dac_enable_n: 1'b1,
        dac_stop: 1'b0,
        cmp_stop: 1'b0
    };
    localparam logic [9:0] CODE_RST = 10'h000;

endpackage

// [verilog/cdac_sync.sv]
`timescale 1ns/1ps

// two-stage synchroniser for the asynchronous analog and trigger inputs
module cdac_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [cdac_pkg::SYNC_W-1:0] async_in,
    output logic [cdac_pkg::SYNC_W-1:0] sync_out
);

    typedef struct packed {
        logic [cdac_pkg::SYNC_W-1:0] meta;
        logic [cdac_pkg::SYNC_W-1:0] stable;
    } cdac_sync_state_s;

    cdac_sync_state_s st;
    cdac_sync_state_s next_st;

    // first stage feeds only the second stage
    always_comb begin
        next_st = st;
        next_st.meta = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;

endmodule // cdac_sync

// [verilog/cdac_ctrl.sv]
`timescale 1ns/1ps

// Summary of operation
// (RULE_01) The first comparator gets a 2-bit positive select, 01 for input one and 10 for input two.
// (RULE_02) The first comparator gets a 3-bit negative select: 001..011 external, 100..111 quarter to full reference.
// (RULE_03) Each comparator gets a speed/power bit (0 fast, 1 low power) and an active-low enable.
// (RULE_04) Each comparator gets a hysteresis bit, 1 turning hysteresis on.
// (RULE_05) The second comparator gets its own independent copy of the full control set and has its own result.
// (RULE_06) One shared stop bit powers the comparator pair down when 1.
// (RULE_07) Each comparator result is offered both to pins and to the timer trigger logic.
// (RULE_08) The converters take an active-low enable and a stop bit that powers them down when 1.
// (RULE_09) Each converter output buffer has an active-low enable, 1 bypassing the buffer.
// (RULE_10) Each converter receives a 10-bit unsigned code, output equal to reference times code over 1024.
// (RULE_11) The converters update independently, or both at once from one trigger in dual mode.
// (RULE_12) A new code reaches a converter only on an external trigger event.
// (RULE_13) Selects, modes and codes stay stable while the macro is enabled and change only on clock edges; only the comparator fields are held while enabled.
module cdac_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cdac_pkg::ADDR_W-1:0] paddr,
    input wire logic [cdac_pkg::DATA_W-1:0] pwdata,
    output logic [cdac_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_a_result,
    input wire logic cmp_b_result,
    input wire logic dac0_trigger,
    input wire logic dac1_trigger,
    output logic [cdac_pkg::POS_SEL_W-1:0] cmp_a_pos_select,
    output logic [cdac_pkg::NEG_SEL_W-1:0] cmp_a_neg_select,
    output logic cmp_a_speed_power,
    output logic cmp_a_hysteresis_on,
    output logic cmp_a_enable_n,
    output logic [cdac_pkg::POS_SEL_W-1:0] cmp_b_pos_select,
    output logic [cdac_pkg::NEG_SEL_W-1:0] cmp_b_neg_select,
    output logic cmp_b_speed_power,
    output logic cmp_b_hysteresis_on,
    output logic cmp_b_enable_n,
    output logic cmp_stop,
    output logic cmp_a_pin_level,
    output logic cmp_b_pin_level,
    output logic cmp_a_timer_trigger,
    output logic cmp_b_timer_trigger,
    output logic dac_enable_n,
    output logic dac_stop,
    output logic dac0_buffer_enable_n,
    output logic dac1_buffer_enable_n,
    output logic [cdac_pkg::CODE_W-1:0] dac0_code,
    output logic [cdac_pkg::CODE_W-1:0] dac1_code
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        cdac_pkg::cdac_cmp_cfg_s cmp_a;
        cdac_pkg::cdac_cmp_cfg_s cmp_b;
        cdac_pkg::cdac_glb_s glb;
        logic [cdac_pkg::CODE_W-1:0] hold0;
        logic [cdac_pkg::CODE_W-1:0] hold1;
        logic [cdac_pkg::CODE_W-1:0] code0;
        logic [cdac_pkg::CODE_W-1:0] code1;
        logic pend0;
        logic pend1;
        logic [1:0] trig_prev;
        logic [1:0] cmp_level;
        logic [1:0] cmp_rise;
        logic [cdac_pkg::DATA_W-1:0] rdata;
    } cdac_state_s;

    localparam cdac_state_s STATE_RST = '{
        cmp_a: cdac_pkg::CMP_CFG_RST,
        cmp_b: cdac_pkg::CMP_CFG_RST,
        glb: cdac_pkg::GLB_RST,
        hold0: cdac_pkg::CODE_RST,
        hold1: cdac_pkg::CODE_RST,
        code0: cdac_pkg::CODE_RST,
        code1: cdac_pkg::CODE_RST,
        pend0: 1'b0,
        pend1: 1'b0,
        trig_prev: 2'h0,
        cmp_level: 2'h0,
        cmp_rise: 2'h0,
        rdata: 32'h0000_0000
    };

    cdac_state_s st;
    cdac_state_s next_st;
    logic [cdac_pkg::SYNC_W-1:0] sync_in;
    logic [cdac_pkg::SYNC_W-1:0] sync_q;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // used for the error answer and to gate writes
    function automatic logic is_mapped(input logic [cdac_pkg::ADDR_W-1:0] a);
        is_mapped = (a == cdac_pkg::OFS_CMP_A_CTRL) || (a == cdac_pkg::OFS_CMP_B_CTRL)
                 || (a == cdac_pkg::OFS_GLOBAL_CTRL) || (a == cdac_pkg::OFS_DAC0_HOLD)
                 || (a == cdac_pkg::OFS_DAC1_HOLD) || (a == cdac_pkg::OFS_STATUS)
                 || (a == cdac_pkg::OFS_DAC_APPLIED);
    endfunction

    // a running comparator accepts only a change of its enable bit
    function automatic cdac_pkg::cdac_cmp_cfg_s cfg_write(input cdac_pkg::cdac_cmp_cfg_s cur,
                                                         input logic [cdac_pkg::DATA_W-1:0] d);
        cdac_pkg::cdac_cmp_cfg_s upd;
        upd = cdac_pkg::cdac_cmp_cfg_s'(d[cdac_pkg::CFG_W-1:0]);
        if (!cur.enable_n) begin
            cfg_write = cur; // RULE_13
            cfg_write.enable_n = upd.enable_n;
        end else begin
            cfg_write = upd; // RULE_05
        end
    endfunction

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // analog results and triggers come from outside the pclk domain
    assign sync_in = {dac1_trigger, dac0_trigger, cmp_b_result, cmp_a_result};

    cdac_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(sync_in),
        .sync_out(sync_q)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // bus access, trigger handling and result tracking in one pass
    always_comb begin
        logic wr_en;
        logic [1:0] trig_rise;
        logic apply0;
        logic apply1;
        logic [cdac_pkg::DATA_W-1:0] rd;
        apply0 = 1'b0;
        apply1 = 1'b0;
        wr_en = psel && penable && pwrite && is_mapped(paddr);
        trig_rise = {sync_q[cdac_pkg::LANE_TRIG1], sync_q[cdac_pkg::LANE_TRIG0]} & ~st.trig_prev;
        rd = 32'h0000_0000;
        next_st = st;

        // comparator results go to pins as a level and to timers as a pulse
        next_st.cmp_level = {sync_q[cdac_pkg::LANE_CMP_B], sync_q[cdac_pkg::LANE_CMP_A]}; // RULE_07
        next_st.cmp_rise = next_st.cmp_level & ~st.cmp_level; // RULE_07
        next_st.trig_prev = {sync_q[cdac_pkg::LANE_TRIG1], sync_q[cdac_pkg::LANE_TRIG0]};

        // in dual mode trigger 0 moves both codes on the same edge
        if (st.glb.dual_mode) begin
            apply0 = trig_rise[0]; // RULE_11
            apply1 = trig_rise[0]; // RULE_11
        end else begin
            apply0 = trig_rise[0];
            apply1 = trig_rise[1];
        end
        if (apply0) begin
            next_st.code0 = st.hold0; // RULE_12
            next_st.pend0 = 1'b0;
        end
        if (apply1) begin
            next_st.code1 = st.hold1; // RULE_12
            next_st.pend1 = 1'b0;
        end

        // writes land at the access-phase edge; a new code write re-arms pending after an apply
        if (wr_en) begin
            unique case (paddr)
                cdac_pkg::OFS_CMP_A_CTRL: next_st.cmp_a = cfg_write(st.cmp_a, pwdata); // RULE_01 RULE_02
                cdac_pkg::OFS_CMP_B_CTRL: next_st.cmp_b = cfg_write(st.cmp_b, pwdata); // RULE_05
                cdac_pkg::OFS_GLOBAL_CTRL: next_st.glb = cdac_pkg::cdac_glb_s'(pwdata[cdac_pkg::GLB_W-1:0]);
                cdac_pkg::OFS_DAC0_HOLD: begin
                    next_st.hold0 = pwdata[cdac_pkg::CODE_W-1:0]; // RULE_10
                    next_st.pend0 = 1'b1;
                end
                cdac_pkg::OFS_DAC1_HOLD: begin
                    next_st.hold1 = pwdata[cdac_pkg::CODE_W-1:0]; // RULE_10
                    next_st.pend1 = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // read data are captured in the setup cycle so prdata comes from a flop
        if (psel && !penable) begin
            unique case (paddr)
                cdac_pkg::OFS_CMP_A_CTRL: rd[cdac_pkg::CFG_W-1:0] = st.cmp_a;
                cdac_pkg::OFS_CMP_B_CTRL: rd[cdac_pkg::CFG_W-1:0] = st.cmp_b;
                cdac_pkg::OFS_GLOBAL_CTRL: rd[cdac_pkg::GLB_W-1:0] = st.glb;
                cdac_pkg::OFS_DAC0_HOLD: rd[cdac_pkg::CODE_W-1:0] = st.hold0;
                cdac_pkg::OFS_DAC1_HOLD: rd[cdac_pkg::CODE_W-1:0] = st.hold1;
                cdac_pkg::OFS_STATUS: begin
                    rd[cdac_pkg::ST_CMP_A_BIT] = st.cmp_level[0];
                    rd[cdac_pkg::ST_CMP_B_BIT] = st.cmp_level[1];
                    rd[cdac_pkg::ST_PEND0_BIT] = st.pend0;
                    rd[cdac_pkg::ST_PEND1_BIT] = st.pend1;
                end
                cdac_pkg::OFS_DAC_APPLIED: begin
                    rd[cdac_pkg::CODE_W-1:0] = st.code0;
                    rd[cdac_pkg::APPLIED_DAC1_LSB +: cdac_pkg::CODE_W] = st.code1;
                end
                default: rd = 32'h0000_0000;
            endcase
            next_st.rdata = rd;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // every macro input changes only here, on a pclk edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= STATE_RST;
        end else begin
            st <= next_st; // RULE_13
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // zero wait states; unmapped or misaligned offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign prdata = st.rdata;

    // comparator control sets, all straight from flops
    assign cmp_a_pos_select = st.cmp_a.pos_select; // RULE_01
    assign cmp_a_neg_select = st.cmp_a.neg_select; // RULE_02
    assign cmp_a_speed_power = st.cmp_a.speed_power; // RULE_03
    assign cmp_a_hysteresis_on = st.cmp_a.hysteresis_on; // RULE_04
    assign cmp_a_enable_n = st.cmp_a.enable_n; // RULE_03
    assign cmp_b_pos_select = st.cmp_b.pos_select; // RULE_05
    assign cmp_b_neg_select = st.cmp_b.neg_select; // RULE_05
    assign cmp_b_speed_power = st.cmp_b.speed_power; // RULE_05
    assign cmp_b_hysteresis_on = st.cmp_b.hysteresis_on; // RULE_05
    assign cmp_b_enable_n = st.cmp_b.enable_n; // RULE_05
    assign cmp_stop = st.glb.cmp_stop; // RULE_06

    // results, three flops late, plus a rising-edge pulse for the timers
    assign cmp_a_pin_level = st.cmp_level[0]; // RULE_07
    assign cmp_b_pin_level = st.cmp_level[1];
    assign cmp_a_timer_trigger = st.cmp_rise[0]; // RULE_07
    assign cmp_b_timer_trigger = st.cmp_rise[1];

    // converter controls and applied codes
    assign dac_enable_n = st.glb.dac_enable_n; // RULE_08
    assign dac_stop = st.glb.dac_stop; // RULE_08
    assign dac0_buffer_enable_n = st.glb.dac0_buffer_enable_n; // RULE_09
    assign dac1_buffer_enable_n = st.glb.dac1_buffer_enable_n; // RULE_09
    assign dac0_code = st.code0; // RULE_10
    assign dac1_code = st.code1; // RULE_10

endmodule // cdac_ctrl

// [tb/cdac_ctrl_assertions.sv]
`timescale 1ns/1ps

// port-level checks on the controller
module cdac_ctrl_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cdac_pkg::ADDR_W-1:0] paddr,
    input wire logic [cdac_pkg::DATA_W-1:0] pwdata,
    input wire logic cmp_a_result,
    input wire logic cmp_b_result,
    input wire logic dac0_trigger,
    input wire logic dac1_trigger,
    input wire logic [cdac_pkg::POS_SEL_W-1:0] cmp_a_pos_select,
    input wire logic [cdac_pkg::NEG_SEL_W-1:0] cmp_a_neg_select,
    input wire logic cmp_a_speed_power,
    input wire logic cmp_a_hysteresis_on,
    input wire logic cmp_a_enable_n,
    input wire logic [cdac_pkg::POS_SEL_W-1:0] cmp_b_pos_select,
    input wire logic [cdac_pkg::NEG_SEL_W-1:0] cmp_b_neg_select,
    input wire logic cmp_b_speed_power,
    input wire logic cmp_b_hysteresis_on,
    input wire logic cmp_b_enable_n,
    input wire logic cmp_stop,
    input wire logic cmp_a_pin_level,
    input wire logic cmp_a_timer_trigger,
    input wire logic cmp_b_pin_level,
    input wire logic cmp_b_timer_trigger,
    input wire logic dac_enable_n,
    input wire logic dac_stop,
    input wire logic dac0_buffer_enable_n,
    input wire logic dac1_buffer_enable_n,
    input wire logic [cdac_pkg::CODE_W-1:0] dac0_code,
    input wire logic [cdac_pkg::CODE_W-1:0] dac1_code
);
    logic [2:0] warm;
    logic wr;
    logic [7:0] wd;
    logic [6:0] fa;
    // cycles since reset, saturating so the synchronisers have filled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm <= 3'h0;
        end else if (warm != 3'h7) begin
            warm <= warm + 3'h1;
        end
    end
    // write strobe, low data byte, comparator a fields
    assign wr = psel && penable && pwrite;
    assign wd = pwdata[7:0];
    assign fa = {cmp_a_pos_select, cmp_a_neg_select, cmp_a_speed_power, cmp_a_hysteresis_on};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_cfg_a_write: assert property (wr && paddr == cdac_pkg::OFS_CMP_A_CTRL && cmp_a_enable_n
        |=> {fa, cmp_a_enable_n} == $past(wd)) else $error("comparator a fields differ from write");
    a_cfg_a_hold: assert property (!cmp_a_enable_n |=> $stable(fa))
        else $error("comparator a fields moved while enabled");
    a_cfg_b_write: assert property (wr && paddr == cdac_pkg::OFS_CMP_B_CTRL && cmp_b_enable_n
        |=> {cmp_b_pos_select, cmp_b_neg_select, cmp_b_speed_power, cmp_b_hysteresis_on, cmp_b_enable_n} == $past(wd))
        else $error("comparator b fields differ from write");
    a_glb_write: assert property (wr && paddr == cdac_pkg::OFS_GLOBAL_CTRL
        |=> {dac1_buffer_enable_n, dac0_buffer_enable_n, dac_enable_n, dac_stop, cmp_stop} == 5'($past(wd)))
        else $error("shared controls differ from write");
    a_code0_trig: assert property (warm == 3'h7 && !$stable(dac0_code) |-> $past(dac0_trigger, 3))
        else $error("code 0 changed without a trigger");
    a_code1_trig: assert property (warm == 3'h7 && !$stable(dac1_code)
        |-> $past(dac1_trigger, 3) || $past(dac0_trigger, 3)) else $error("code 1 changed without a trigger");
    a_pin_follow: assert property (warm == 3'h7 |-> cmp_a_pin_level == $past(cmp_a_result, 3))
        else $error("pin level does not follow result");
    a_timer_pulse: assert property (warm == 3'h7 |-> cmp_a_timer_trigger == $rose(cmp_a_pin_level))
        else $error("timer pulse does not match rising level");
    a_pin_follow_b: assert property (warm == 3'h7 |-> cmp_b_pin_level == $past(cmp_b_result, 3))
        else $error("pin level b does not follow result");
    a_timer_pulse_b: assert property (warm == 3'h7 |-> cmp_b_timer_trigger == $rose(cmp_b_pin_level))
        else $error("timer pulse b does not match rising level");
endmodule // cdac_ctrl_chk

bind cdac_ctrl cdac_ctrl_chk i_chk (.*);

// [tb/cdac_macro_model.sv]
`timescale 1ns/1ps

// ideal comparator pair and converters, levels in mV
module cdac_macro_model #(
    parameter int VREF_MV = 3300
) (
    input wire logic [1:0] a_pos,
    input wire logic [2:0] a_neg,
    input wire logic a_en_n,
    input wire logic [1:0] b_pos,
    input wire logic [2:0] b_neg,
    input wire logic b_en_n,
    input wire logic stop,
    input wire logic dac_off,
    input wire logic [9:0] code0,
    input wire logic [9:0] code1,
    output logic res_a,
    output logic res_b,
    output int mv0,
    output int mv1
);
    // fixed external inputs; a powered-down comparator drives low
    function automatic logic cmp(input logic [1:0] ps, input logic [2:0] ms, input logic en_n, input logic st);
        int vp;
        int vm;
        vp = ps == 2'h1 ? 1000 : ps == 2'h2 ? 2500 : 0;
        vm = ms[2] ? VREF_MV * (int'(ms[1:0]) + 1) / 4 : ms == 3'h1 ? 4000 : ms == 3'h2 ? 500 : 3000;
        return !en_n && !st && vp > vm;
    endfunction
    // each comparator has its own selects and output
    assign res_a = cmp(a_pos, a_neg, a_en_n, stop);
    assign res_b = cmp(b_pos, b_neg, b_en_n, stop);
    // reference times code over 1024, zero when off
    assign mv0 = dac_off ? 0 : VREF_MV * int'(code0) / 1024;
    assign mv1 = dac_off ? 0 : VREF_MV * int'(code1) / 1024;
endmodule // cdac_macro_model

// [tb/cdac_ctrl_tb_top.sv]
`timescale 1ns/1ps

module cdac_ctrl_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, dac0_trigger = 1'b0, dac1_trigger = 1'b0, cmp_a_result, cmp_b_result;
    logic [1:0] cmp_a_pos_select, cmp_b_pos_select;
    logic [2:0] cmp_a_neg_select, cmp_b_neg_select;
    logic cmp_a_speed_power, cmp_a_hysteresis_on, cmp_a_enable_n, cmp_b_speed_power, cmp_b_hysteresis_on;
    logic cmp_b_enable_n, cmp_stop, cmp_a_pin_level, cmp_b_pin_level, cmp_a_timer_trigger, cmp_b_timer_trigger;
    logic dac_enable_n, dac_stop, dac0_buffer_enable_n, dac1_buffer_enable_n;
    logic [9:0] dac0_code, dac1_code;
    logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
    logic [31:0] rv[5] = '{32'h49, 32'h49, 32'h1c, 32'h0, 32'h0};
    int mv0, mv1, n_fail = 0, n_compared = 0, c, p, m, k, st, g, cfg, dual, trg;
    int vm_tab[8] = '{3000, 4000, 500, 3000, 825, 1650, 2475, 3300};
    int hold[2], code[2] = '{0, 0}, pend[2];

    // 20 MHz clock
    always #25 pclk = ~pclk;

    cdac_ctrl i_dut (.*);
    cdac_macro_model i_macro (.a_pos(cmp_a_pos_select), .a_neg(cmp_a_neg_select), .a_en_n(cmp_a_enable_n),
        .b_pos(cmp_b_pos_select), .b_neg(cmp_b_neg_select), .b_en_n(cmp_b_enable_n), .stop(cmp_stop),
        .dac_off(dac_enable_n | dac_stop), .code0(dac0_code), .code1(dac1_code), .res_a(cmp_a_result),
        .res_b(cmp_b_result), .mv0(mv0), .mv1(mv1));

    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits on pready but never past the bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            end_sim();
        end else begin
            @(posedge pclk);
        end
    endtask

    // reset values of every mapped word except the two hold words
    task automatic chk_rst();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 0);
            chk(rd, rv[i]);
        end
    endtask

    // hang guard
    initial begin
        #4000000;
        n_fail++;
        end_sim();
    end

    initial begin
        void'($urandom(72243));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_rst();
        // every select pair on both comparators, stop and shared bits random
        for (k = 0; k < 28; k++) begin
            c = k / 14;
            p = 1 + (k / 7) % 2;
            m = 1 + k % 7;
            cfg = {p[1:0], m[2:0], 2'($urandom), 1'b1};
            st = $urandom % 2;
            g = (($urandom % 16) << 1) | st;
            apb(1'b1, 8'(c * 4), 1);
            apb(1'b1, 8'(c * 4), cfg);
            apb(1'b1, 8'(c * 4), cfg - 1);
            apb(1'b1, 8'(c * 4), ~cfg & 32'hfe); // fields must stay while enabled
            apb(1'b1, 8'h08, g);
            repeat (3) @(posedge pclk);
            apb(1'b0, 8'(c * 4), 0);
            chk(rd, cfg - 1);
            chk(c ? {cmp_b_pos_select, cmp_b_neg_select, cmp_b_speed_power, cmp_b_hysteresis_on, cmp_b_enable_n} :
                {cmp_a_pos_select, cmp_a_neg_select, cmp_a_speed_power, cmp_a_hysteresis_on, cmp_a_enable_n}, cfg - 1);
            chk({dac1_buffer_enable_n, dac0_buffer_enable_n, dac_enable_n, dac_stop, cmp_stop}, g);
            chk(c ? cmp_b_pin_level : cmp_a_pin_level, !st && (p == 1 ? 1000 : 2500) > vm_tab[m]);
        end
        // converters: independent, then dual from trigger 0 only
        for (k = 0; k < 8; k++) begin
            dual = k / 4;
            apb(1'b1, 8'h08, dual << 5);
            for (c = 0; c < 2; c++) begin
                hold[c] = k == 0 ? 1023 : $urandom % 1024;
                pend[c] = 1;
                apb(1'b1, 8'(12 + c * 4), hold[c]);
            end
            chk({dac1_code, dac0_code}, {code[1][9:0], code[0][9:0]});
            trg = $urandom % 2;
            dac0_trigger <= trg == 0;
            dac1_trigger <= trg == 1;
            repeat (2) @(posedge pclk);
            dac0_trigger <= 1'b0;
            dac1_trigger <= 1'b0;
            repeat (4) @(posedge pclk);
            for (c = 0; c < 2; c++) begin
                if (dual ? trg == 0 : c == trg) begin
                    code[c] = hold[c];
                    pend[c] = 0;
                end
            end
            apb(1'b0, 8'h18, 0);
            chk(rd, {6'h0, code[1][9:0], 6'h0, code[0][9:0]});
            apb(1'b0, 8'h14, 0);
            chk(rd[3:2], {pend[1][0], pend[0][0]});
            chk(mv0, 3300 * code[0] / 1024);
            chk(mv1, 3300 * code[1] / 1024);
        end
        // unmapped and misaligned places give an error, unmapped places read zero
        for (k = 0; k < 3; k++) begin
            apb(k[0], k == 0 ? 8'h1c : k == 1 ? 8'h02 : 8'hfc, 32'hffffffff);
            chk(err, 1);
            chk(rd & {32{!k[0]}}, 0);
        end
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_rst();
        end_sim();
    end
endmodule // cdac_ctrl_tb_top
